// ### common/tsa_params.svh
// Purpose: constants of the station admission block
// Assumes: included by the block and its bench
// Notes:   byte addresses on the plain register port
`ifndef TSA_PARAMS_SVH
`define TSA_PARAMS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define TSA_ADDR_CTRL  8'h00
`define TSA_ADDR_SUCC  8'h04
`define TSA_ADDR_STAT  8'h08
`define TSA_ADDR_MASK  8'h0C
`define TSA_ADDR_STATE 8'h10
`define TSA_CTRL_RING  8
`define TSA_CTRL_WANT  9
`define TSA_ST_SCAN    2
// ----------------------------------------
// Event bits
// ----------------------------------------
`define TSA_EV_SCAN    0
`define TSA_EV_FOUND   1
`define TSA_EV_POLL    2
`define TSA_EV_RECOV   3
`define TSA_EV_W       4
// ----------------------------------------
// Station numbers, reset values, timing
// ----------------------------------------
`define TSA_STN_FIRST  8'h01
`define TSA_STN_LAST   8'hFE
`define TSA_STN_BCAST  8'hFF
`define TSA_RST_OWN    8'h01
`define TSA_RST_SUCC   8'h02
`define TSA_CLK_NS     4
`define TSA_ACK_NS     20000
`define TSA_PASS_TRIES 2'h2
`endif

// ### common/tsa_pkg.sv
// Purpose: types of the station admission block
// Assumes: nothing
// Notes:   access control byte laid out msb first
package tsa_pkg;
    typedef struct packed {
        logic       scan;
        logic       wants;
        logic [2:0] rsvd;
        logic [2:0] nval;
    } tsa_ac_t;
    typedef struct packed {
        logic       timeout;
        logic       wants;
        logic [2:0] nval;
    } tsa_fsb_t;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tsa_bus_t;
    typedef enum logic [1:0] {
        TSA_IDLE     = 2'b00,
        TSA_TOK_WAIT = 2'b01,
        TSA_ACK_WAIT = 2'b10
    } tsa_state_t;
endpackage

// ### verilog/tsa_admission.sv
// Purpose: station admission of a token access controller
// Assumes: frame layer on the same clock; it sends what we ask
// Notes:   one timer shared by token pass and ack poll
`timescale 1ns/1ps
`include "tsa_params.svh"

module tsa_admission #(
    parameter int ACK_WAIT_NS = `TSA_ACK_NS,
    parameter int TMR_W       = 16
) (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               resetn_i,
    // Register port
    input  wire tsa_pkg::tsa_bus_t  bus_i,
    output logic [31:0]             rdata_o,
    // Received access frame
    input  wire logic               rx_ac_valid_i,
    input  wire logic [7:0]         rx_da_i,
    input  wire tsa_pkg::tsa_ac_t   rx_ac_i,
    // Token pass
    input  wire logic               pass_req_i,
    input  wire logic               tok_resp_i,
    output logic                    tok_send_o,
    output logic [7:0]              tok_dest_o,
    // Acknowledged poll
    input  wire logic               poll_start_i,
    input  wire logic               poll_reply_i,
    input  wire tsa_pkg::tsa_ac_t   poll_ac_i,
    output logic                    fsb_wr_o,
    output tsa_pkg::tsa_fsb_t       fsb_o,
    // Ack response
    input  wire logic               ack_req_i,
    input  wire logic [2:0]         ack_nval_i,
    output logic                    ack_resp_o,
    output tsa_pkg::tsa_ac_t        ack_ac_o,
    // Interrupt
    output logic                    irq_o
);

    localparam int ACK_CYC_I = ACK_WAIT_NS / `TSA_CLK_NS;
    localparam logic [TMR_W-1:0] ACK_CYC =
        TMR_W'((ACK_CYC_I < 1) ? 1 : ACK_CYC_I);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] next_stn(input logic [7:0] n);
        next_stn = (n >= `TSA_STN_LAST) ? `TSA_STN_FIRST : n + 8'h01;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    tsa_pkg::tsa_state_t       st_q, st_d;
    logic [TMR_W-1:0]          tmr_q, tmr_d;
    logic [7:0]                own_q, own_d;
    logic [7:0]                succ_q, succ_d;
    logic [7:0]                dest_q, dest_d;
    logic [1:0]                tries_q, tries_d;
    logic                      scan_q, scan_d;
    logic                      ring_q, ring_d;
    logic                      want_q, want_d;
    logic [`TSA_EV_W-1:0]      stat_q, stat_d;
    logic [`TSA_EV_W-1:0]      mask_q, mask_d;
    logic [`TSA_EV_W-1:0]      ev;
    logic                      send_q, send_d;
    logic                      fsbw_q, fsbw_d;
    tsa_pkg::tsa_fsb_t         fsb_q, fsb_d;
    logic                      aresp_q;
    tsa_pkg::tsa_ac_t          aac_q, aac_d;
    logic [31:0]               rdata_q, rdata_d;
    logic                      irq_q, irq_d;
    logic                      scan_cmd;
    logic                      wr_succ;

    // Broadcast or own address both count
    assign scan_cmd = rx_ac_valid_i && rx_ac_i.scan &&
        (rx_da_i == own_q || rx_da_i == `TSA_STN_BCAST);
    assign wr_succ = bus_i.wr && bus_i.addr == `TSA_ADDR_SUCC;

    // ----------------------------------------
    // Admission sequencer
    // ----------------------------------------
    always_comb begin
        st_d    = st_q;
        tmr_d   = tmr_q;
        succ_d  = succ_q;
        dest_d  = dest_q;
        tries_d = tries_q;
        scan_d  = scan_q;
        send_d  = 1'b0;
        fsbw_d  = 1'b0;
        fsb_d   = fsb_q;
        ev      = '0;
        // Host write ends a scan in progress; a same-cycle scan step by the sequencer wins
        if (wr_succ) begin
            succ_d = bus_i.wdata[7:0];
            scan_d = 1'b0;
        end
        unique case (st_q)
            tsa_pkg::TSA_IDLE: begin
                if (pass_req_i) begin
                    send_d  = 1'b1;
                    dest_d  = succ_q;
                    tries_d = 2'h1;
                    tmr_d   = ACK_CYC;
                    st_d    = tsa_pkg::TSA_TOK_WAIT;
                end else if (poll_start_i) begin
                    tmr_d = ACK_CYC;
                    st_d  = tsa_pkg::TSA_ACK_WAIT;
                end
            end
            tsa_pkg::TSA_TOK_WAIT: begin
                if (tok_resp_i) begin
                    st_d = tsa_pkg::TSA_IDLE;
                    if (scan_q) begin
                        succ_d = dest_q;
                        scan_d = 1'b0;
                        ev[`TSA_EV_FOUND] = 1'b1;
                    end
                end else if (tmr_q == '0) begin
                    send_d = 1'b1;
                    tmr_d  = ACK_CYC;
                    if (scan_q || tries_q == `TSA_PASS_TRIES) begin
                        // One try per candidate, wrap in 1..254
                        dest_d  = next_stn(dest_q);
                        succ_d  = next_stn(dest_q);
                        tries_d = 2'h1;
                        scan_d  = 1'b1;
                        if (!scan_q) ev[`TSA_EV_RECOV] = 1'b1;
                    end else begin
                        tries_d = tries_q + 2'h1;
                    end
                end else begin
                    tmr_d = tmr_q - TMR_W'(1);
                end
            end
            tsa_pkg::TSA_ACK_WAIT: begin
                if (poll_reply_i) begin
                    fsbw_d = 1'b1;
                    fsb_d  = '{timeout: 1'b0, wants: poll_ac_i.wants,
                               nval: poll_ac_i.nval};
                    ev[`TSA_EV_POLL] = 1'b1;
                    st_d = tsa_pkg::TSA_IDLE;
                end else if (tmr_q == '0) begin
                    fsbw_d = 1'b1;
                    fsb_d  = '{timeout: 1'b1, wants: 1'b0, nval: 3'h0};
                    ev[`TSA_EV_POLL] = 1'b1;
                    st_d = tsa_pkg::TSA_IDLE;
                end else begin
                    tmr_d = tmr_q - TMR_W'(1);
                end
            end
            default: st_d = tsa_pkg::TSA_IDLE;
        endcase
        // Scan command wins over host write and sequencer
        if (scan_cmd) begin
            succ_d = next_stn(own_q);
            scan_d = 1'b1;
            ev[`TSA_EV_SCAN] = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q    <= tsa_pkg::TSA_IDLE;
            tmr_q   <= '0;
            succ_q  <= `TSA_RST_SUCC;
            dest_q  <= `TSA_RST_SUCC;
            tries_q <= 2'h0;
            scan_q  <= 1'b0;
            send_q  <= 1'b0;
            fsbw_q  <= 1'b0;
            fsb_q   <= '0;
        end else begin
            st_q    <= st_d;
            tmr_q   <= tmr_d;
            succ_q  <= succ_d;
            dest_q  <= dest_d;
            tries_q <= tries_d;
            scan_q  <= scan_d;
            send_q  <= send_d;
            fsbw_q  <= fsbw_d;
            fsb_q   <= fsb_d;
        end
    end

    // ----------------------------------------
    // Ack response
    // ----------------------------------------
    // Wants from host bits, nval passed from ack_nval_i; no host action per reply
    always_comb begin
        aac_d       = '0;
        aac_d.wants = want_q && !ring_q;
        aac_d.nval  = ack_nval_i;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aresp_q <= 1'b0;
            aac_q   <= '0;
        end else begin
            aresp_q <= ack_req_i;
            aac_q   <= aac_d;
        end
    end

    // ----------------------------------------
    // Registers and interrupt
    // ----------------------------------------
    always_comb begin
        own_d  = own_q;
        ring_d = ring_q;
        want_d = want_q;
        mask_d = mask_q;
        stat_d = stat_q;
        if (bus_i.wr && bus_i.addr == `TSA_ADDR_CTRL) begin
            own_d  = bus_i.wdata[7:0];
            ring_d = bus_i.wdata[`TSA_CTRL_RING];
            want_d = bus_i.wdata[`TSA_CTRL_WANT];
        end
        if (bus_i.wr && bus_i.addr == `TSA_ADDR_MASK)
            mask_d = bus_i.wdata[`TSA_EV_W-1:0];
        if (bus_i.wr && bus_i.addr == `TSA_ADDR_STAT)
            stat_d = stat_q & ~bus_i.wdata[`TSA_EV_W-1:0];
        // Set wins over a same-cycle clear
        stat_d  = stat_d | ev;
        irq_d   = |(stat_q & mask_q);
        rdata_d = 32'h0;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                `TSA_ADDR_CTRL:  rdata_d = {22'h0, want_q, ring_q, own_q};
                `TSA_ADDR_SUCC:  rdata_d = {24'h0, succ_q};
                `TSA_ADDR_STAT:  rdata_d = {28'h0, stat_q};
                `TSA_ADDR_MASK:  rdata_d = {28'h0, mask_q};
                `TSA_ADDR_STATE: rdata_d = {21'h0, dest_q, scan_q, st_q};
                default:         rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            own_q   <= `TSA_RST_OWN;
            ring_q  <= 1'b0;
            want_q  <= 1'b0;
            mask_q  <= '0;
            stat_q  <= '0;
            rdata_q <= 32'h0;
            irq_q   <= 1'b0;
        end else begin
            own_q   <= own_d;
            ring_q  <= ring_d;
            want_q  <= want_d;
            mask_q  <= mask_d;
            stat_q  <= stat_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    assign rdata_o    = rdata_q;
    assign tok_send_o = send_q;
    assign tok_dest_o = dest_q;
    assign fsb_wr_o   = fsbw_q;
    assign fsb_o      = fsb_q;
    assign ack_resp_o = aresp_q;
    assign ack_ac_o   = aac_q;
    assign irq_o      = irq_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    sequence s_scan_miss;
        st_q == tsa_pkg::TSA_TOK_WAIT && scan_q && tmr_q == '0
            && !tok_resp_i && !scan_cmd;
    endsequence
    sequence s_poll_end;
        st_q == tsa_pkg::TSA_ACK_WAIT && tmr_q == '0 && !poll_reply_i;
    endsequence
    a_scan_reload: assert property (scan_cmd |=>
        succ_q == next_stn($past(own_q)) && scan_q)
        else $error("scan did not reload successor");
    a_scan_bcast: assert property (rx_ac_valid_i && rx_ac_i.scan
        && rx_da_i == `TSA_STN_BCAST |=> scan_q)
        else $error("broadcast scan ignored");
    a_scan_notify: assert property (scan_cmd |=>
        stat_q[`TSA_EV_SCAN] ##1 (irq_o || !$past(mask_q[`TSA_EV_SCAN])))
        else $error("scan change not reported");
    a_scan_next: assert property (s_scan_miss |=>
        tok_send_o && tok_dest_o == next_stn($past(dest_q)))
        else $error("scan did not advance candidate");
    a_scan_once: assert property (s_scan_miss |=>
        tries_q == 2'h1 && tok_dest_o != $past(dest_q))
        else $error("candidate tried twice");
    a_scan_range: assert property (scan_q |->
        succ_q != 8'h00 && succ_q != `TSA_STN_BCAST)
        else $error("scan left station range");
    a_found_stop: assert property (st_q == tsa_pkg::TSA_TOK_WAIT
        && scan_q && tok_resp_i && !scan_cmd && !wr_succ
        |=> !scan_q && succ_q == $past(dest_q))
        else $error("responder not stored");
    a_poll_tmo: assert property (s_poll_end |=>
        fsb_wr_o && fsb_o.timeout ##1 !fsb_wr_o)
        else $error("poll timeout not written");
    a_poll_ok: assert property (st_q == tsa_pkg::TSA_ACK_WAIT
        && poll_reply_i |=> fsb_wr_o && !fsb_o.timeout
        && fsb_o.wants == $past(poll_ac_i.wants)
        && st_q == tsa_pkg::TSA_IDLE)
        else $error("poll reply not written");
    a_ack_wants: assert property (ack_req_i |=> ack_resp_o
        && ack_ac_o.wants == ($past(want_q) && !$past(ring_q))
        && !ack_ac_o.scan)
        else $error("ack reply status wrong");
    a_ack_copy: assert property (ack_req_i && ring_q |=>
        !ack_ac_o.wants)
        else $error("ring member claims wants-in");
endmodule // tsa_admission

// ### dv/tsa_peer.sv
// Purpose: peer stations on the shared link
// Assumes: one station answers tokens, polls answered on command
// Notes:   delay below the block's wait timer, or it times out
`timescale 1ns/1ps

module tsa_peer (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    // Set-up from the bench
    input  wire logic [7:0]       here_i,
    input  wire logic [3:0]       dly_i,
    input  wire logic             poll_here_i,
    input  wire tsa_pkg::tsa_ac_t reply_ac_i,
    // Traffic from the block
    input  wire logic             tok_send_i,
    input  wire logic [7:0]       tok_dest_i,
    input  wire logic             poll_start_i,
    // Answers
    output logic                  tok_resp_o,
    output logic                  poll_reply_o,
    output tsa_pkg::tsa_ac_t      poll_ac_o
);
    logic [4:0] tok_cnt;
    logic [4:0] poll_cnt;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tok_cnt      <= 5'h00;
            poll_cnt     <= 5'h00;
            tok_resp_o   <= 1'b0;
            poll_reply_o <= 1'b0;
            poll_ac_o    <= 8'h00;
        end else begin
            tok_resp_o   <= (tok_cnt == 5'h01);
            poll_reply_o <= (poll_cnt == 5'h01);
            // Released field inverts each cycle, so the old reply shows again every other cycle
            poll_ac_o    <= (poll_cnt == 5'h01) ? reply_ac_i : ~poll_ac_o;
            if (tok_send_i && tok_dest_i == here_i)
                tok_cnt <= {1'b0, dly_i} + 5'h01;
            else if (tok_cnt != 5'h00)
                tok_cnt <= tok_cnt - 5'h01;
            if (poll_start_i && poll_here_i)
                poll_cnt <= {1'b0, dly_i} + 5'h02;
            else if (poll_cnt != 5'h00)
                poll_cnt <= poll_cnt - 5'h01;
        end
    end
endmodule // tsa_peer

// ### dv/tsa_admission_test.sv
// Purpose: self-checking bench of the station admission block
// Assumes: wait timer shortened to 10 cycles
// Notes:   one task per scenario
`timescale 1ns/1ps
`include "tsa_params.svh"
`define TB_CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, g); end end

module tsa_admission_test;
    logic clock_i = 1'b0, resetn_i = 1'b0;
    tsa_pkg::tsa_bus_t bus = '0;
    logic [31:0] rdata_o;
    logic rx_v = 1'b0, pass_req = 1'b0, poll_start = 1'b0;
    logic ack_req = 1'b0, tok_resp, tok_send, fsb_wr, ack_resp, irq_o;
    logic poll_reply, poll_here = 1'b0;
    logic [7:0] rx_da = 8'h00, tok_dest, here = 8'h00;
    logic [2:0] ack_nval = 3'h0;
    logic [3:0] dly = 4'h0;
    tsa_pkg::tsa_ac_t rx_ac = '0, poll_ac, ack_ac, reply_ac = '0;
    tsa_pkg::tsa_fsb_t fsb;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    logic [7:0] sent[$];

    initial forever #2 clock_i = ~clock_i;

    tsa_admission #(.ACK_WAIT_NS(40)) DUT (.clock_i(clock_i),
        .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata_o),
        .rx_ac_valid_i(rx_v), .rx_da_i(rx_da), .rx_ac_i(rx_ac),
        .pass_req_i(pass_req), .tok_resp_i(tok_resp),
        .tok_send_o(tok_send), .tok_dest_o(tok_dest),
        .poll_start_i(poll_start), .poll_reply_i(poll_reply),
        .poll_ac_i(poll_ac), .fsb_wr_o(fsb_wr), .fsb_o(fsb),
        .ack_req_i(ack_req), .ack_nval_i(ack_nval),
        .ack_resp_o(ack_resp), .ack_ac_o(ack_ac), .irq_o(irq_o));

    tsa_peer peer (.clock_i(clock_i), .resetn_i(resetn_i),
        .here_i(here), .dly_i(dly), .poll_here_i(poll_here),
        .reply_ac_i(reply_ac), .tok_send_i(tok_send),
        .tok_dest_i(tok_dest), .poll_start_i(poll_start),
        .tok_resp_o(tok_resp), .poll_reply_o(poll_reply),
        .poll_ac_o(poll_ac));

    // ----------------------------------------
    // Monitor and hang guard
    // ----------------------------------------
    always @(posedge clock_i) begin
        if (tok_send === 1'b1)
            sent.push_back(tok_dest);
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ----------------------------------------
    // Bus and pulse tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i) bus.wr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        @(posedge clock_i) bus <= '{addr: a, wdata: 0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i) bus.rd <= 1'b0;
        #1 `TB_CHK(nm, e, rdata_o)
    endtask

    task automatic rx(input logic [7:0] da, input logic [7:0] ac);
        @(posedge clock_i) begin
            rx_v  <= 1'b1;
            rx_da <= da;
            rx_ac <= ac;
        end
        @(posedge clock_i) rx_v <= 1'b0;
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 200 && irq_o !== 1'b1; i++)
            @(posedge clock_i);
        #1 `TB_CHK("irq", 1'b1, irq_o)
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk("ctrl", `TSA_ADDR_CTRL, 32'h0000_0001);
        rd_chk("succ", `TSA_ADDR_SUCC, 32'h0000_0002);
        rd_chk("stat", `TSA_ADDR_STAT, 32'h0000_0000);
        rd_chk("unmapped", 8'h14, 32'h0000_0000);
    endtask

    task automatic t_scan_cmd();
        wr(`TSA_ADDR_CTRL, 32'h10);
        wr(`TSA_ADDR_MASK, 32'h1);
        rx(8'h10, 8'h80);
        rd_chk("succ", `TSA_ADDR_SUCC, 32'h11);
        rd_chk("stat", `TSA_ADDR_STAT, 32'h01);
        `TB_CHK("irq", 1'b1, irq_o)
        wr(`TSA_ADDR_STAT, 32'h1);
        wr(`TSA_ADDR_SUCC, 32'h30);
        rx(8'h33, 8'h80);
        rx(8'h10, 8'h40);
        rd_chk("succ", `TSA_ADDR_SUCC, 32'h30);
        `TB_CHK("irq", 1'b0, irq_o)
        wr(`TSA_ADDR_CTRL, 32'hFE);
        rx(`TSA_STN_BCAST, 8'h80);
        rd_chk("succ", `TSA_ADDR_SUCC, 32'h01);
        wr(`TSA_ADDR_STAT, 32'h1F);
        wr(`TSA_ADDR_MASK, 32'h0);
    endtask

    task automatic t_pass();
        logic [7:0] exp[5] = '{8'hFD, 8'hFD, 8'hFE, 8'h01, 8'h02};
        wr(`TSA_ADDR_CTRL, 32'h10);
        wr(`TSA_ADDR_SUCC, 32'h20);
        here <= 8'h20;
        dly  <= 4'h7;
        sent.delete();
        @(posedge clock_i) pass_req <= 1'b1;
        @(posedge clock_i) pass_req <= 1'b0;
        repeat (14) @(posedge clock_i);
        `TB_CHK("sends", 1, sent.size())
        rd_chk("succ", `TSA_ADDR_SUCC, 32'h20);
        // Only station 2 answers: the scan wraps past 254
        wr(`TSA_ADDR_SUCC, 32'hFD);
        wr(`TSA_ADDR_MASK, 32'h2);
        here <= 8'h02;
        dly  <= 4'h0;
        sent.delete();
        @(posedge clock_i) pass_req <= 1'b1;
        @(posedge clock_i) pass_req <= 1'b0;
        wait_irq();
        `TB_CHK("sends", 5, sent.size())
        for (int i = 0; i < 5 && i < sent.size(); i++)
            `TB_CHK("dest", exp[i], sent[i])
        rd_chk("succ", `TSA_ADDR_SUCC, 32'h02);
        rd_chk("stat", `TSA_ADDR_STAT, 32'h0A);
        rd_chk("state", `TSA_ADDR_STATE, 32'h10);
        wr(`TSA_ADDR_STAT, 32'h1F);
        wr(`TSA_ADDR_MASK, 32'h0);
    endtask

    task automatic t_poll();
        logic [4:0] e;
        int w;
        reply_ac <= 8'h43;
        dly      <= 4'h5;
        // Host walks the gap one station per poll tick
        for (int s = 5; s < 8; s++) begin
            poll_here <= (s == 7);
            @(posedge clock_i) poll_start <= 1'b1;
            @(posedge clock_i) poll_start <= 1'b0;
            for (w = 0; w < 40 && fsb_wr !== 1'b1; w++)
                @(posedge clock_i);
            `TB_CHK("fsb_wr", 1'b1, fsb_wr)
            `TB_CHK("poll_cyc", (s == 7) ? 9 : 12, w)
            e = (s == 7) ? 5'b0_1_011 : 5'b1_0_000;
            #1 `TB_CHK("fsb", e, fsb)
            rd_chk("stat", `TSA_ADDR_STAT, 32'h04);
            wr(`TSA_ADDR_STAT, 32'h04);
        end
        wr(`TSA_ADDR_SUCC, 32'h07);
        rd_chk("succ", `TSA_ADDR_SUCC, 32'h07);
    endtask

    task automatic t_ack();
        logic [7:0] e;
        for (int i = 0; i < 5; i++) begin
            wr(`TSA_ADDR_CTRL, {22'h0, i[1], i[0], 8'h10});
            @(posedge clock_i) begin
                ack_req  <= 1'b1;
                ack_nval <= i[2:0];
            end
            @(posedge clock_i) ack_req <= 1'b0;
            e = {1'b0, i[1] & ~i[0], 3'h0, i[2:0]};
            #1 `TB_CHK("ack_resp", 1'b1, ack_resp)
            `TB_CHK("ack_ac", e, ack_ac)
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_reset();
        t_scan_cmd();
        t_pass();
        t_poll();
        t_ack();
        test_done();
    end
endmodule // tsa_admission_test
